// >>> verif/afe_props.sv
`default_nettype none
module afe_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        sample_strobe_in,
  input wire logic        timing_strobe,
  input wire logic [3:0]  cell_power_disable,
  input wire logic [7:0]  red_offset_code,
  input wire logic [7:0]  green_offset_code,
  input wire logic [7:0]  blue_offset_code,
  input wire logic [8:0]  red_gain_code,
  input wire logic [8:0]  green_gain_code,
  input wire logic [8:0]  blue_gain_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wr_q;
  logic [7:0] idx_q;
  logic [7:0] sh_q [0:8];
  logic       pin_q;
  logic [9:0] ev_q;
  logic [3:0] sc_q;
  logic [1:0] qc_q;
  wire        wdone = wr_q && hready;
  wire  [7:0] st = sh_q[5];
  wire        edge_now = st[0] && (st[4] ? sample_strobe_in && !pin_q : !sample_strobe_in && pin_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      idx_q <= 8'h00;
      pin_q <= 1'b0;
      ev_q <= 10'h000;
      sc_q <= 4'h0;
      qc_q <= 2'h0;
      for (int i = 0; i < 9; i++) sh_q[i] <= 8'h00;
    end else begin
      if (hready) begin
        wr_q <= hsel && htrans[1] && hwrite;
        idx_q <= haddr[9:2];
      end
      if (wdone && idx_q < 8'h09) sh_q[idx_q[3:0]] <= hwdata[7:0];
      pin_q <= sample_strobe_in;
      ev_q <= {ev_q[8:0], edge_now};
      sc_q <= (wdone && idx_q == 8'h05) ? 4'h0 : sc_q + {3'h0, sc_q != 4'hf};
      qc_q <= wdone ? 2'h0 : qc_q + {1'b0, qc_q != 2'h3};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pin_copy: assert property ((!st[0]) [*4] |-> timing_strobe == $past(sample_strobe_in, 3))
    else $error("strobe copy wrong");
  a_pulse_delay: assert property (st[0] && sc_q >= 4'hc |-> timing_strobe == ev_q[2 + st[3:1]])
    else $error("strobe pulse wrong");
  a_pulse_single: assert property (st[0] && sc_q > 4'h1 && timing_strobe |=> !timing_strobe)
    else $error("pulse too long");
  a_mask_gated: assert property (qc_q == 2'h3 |-> cell_power_disable == (sh_q[8][0] ? sh_q[6][3:0] : 4'h0))
    else $error("power mask wrong");
  a_write_no_wait: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
    else $error("write wait");
  a_read_one_wait: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_offset_all: assert property (wdone && idx_q == 8'h23 |=>
    {red_offset_code, green_offset_code, blue_offset_code} == {3{$past(hwdata[7:0])}}) else $error("offset all");
  a_gain_all: assert property (wdone && idx_q == 8'h2b |=>
    {red_gain_code[8:1], green_gain_code[8:1], blue_gain_code[8:1]} == {3{$past(hwdata[7:0])}}) else $error("gain all");
  a_gain_low_all: assert property (wdone && idx_q == 8'h27 |=>
    {red_gain_code[0], green_gain_code[0], blue_gain_code[0]} == {3{$past(hwdata[0])}}) else $error("gain low all");
  cover property (st[0] && timing_strobe);
  cover property (wdone && idx_q == 8'h27);
  cover property (sh_q[8][0] && cell_power_disable != 4'h0);
endmodule // afe_props
bind afe_setup_gain_offset_regs afe_props i_afe_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .sample_strobe_in, .timing_strobe, .cell_power_disable, .red_offset_code,
  .green_offset_code, .blue_offset_code, .red_gain_code, .green_gain_code, .blue_gain_code);
`default_nettype wire

// >>> verif/strobe_source.sv
`default_nettype none
module strobe_source (
  input  wire logic hclk,
  input  wire logic hresetn,
  output var logic  strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_q;
  // Levels last 6 to 10 cycles, so like edges lie further apart than the longest delay.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe <= 1'b0;
      left_q <= 4'h8;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end else begin
      strobe <= !strobe;
      left_q <= 4'h5 + 4'($urandom_range(4));
    end
  end
endmodule // strobe_source
`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        rd_ph = 1'b0;
  wire         hreadyout, hresp, strobe, timing_strobe, fast_bias_sel, gain_law_sel;
  wire  [31:0] hrdata;
  wire  [3:0]  cell_power_disable;
  wire  [7:0]  red_offset_code, green_offset_code, blue_offset_code;
  wire  [8:0]  red_gain_code, green_gain_code, blue_gain_code;
  int          n_fail;
  int          total_checks;
  int          cycles = 0;
  int          k;
  logic [31:0] exp_q [$];
  logic [7:0]  m [0:63];
  logic [7:0]  ix [17] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
                           8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h3f};
  logic [7:0]  mk [17] = '{0: 8'h1f, 1: 8'h0f, 2: 8'h02, 3: 8'h03, default: 8'hff};
  afe_setup_gain_offset_regs i_afe_setup_gain_offset_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sample_strobe_in(strobe),
    .timing_strobe, .cell_power_disable, .fast_bias_sel, .gain_law_sel, .red_offset_code, .green_offset_code,
    .blue_offset_code, .red_gain_code, .green_gain_code, .blue_gain_code);
  strobe_source i_strobe_source (.hclk, .hresetn, .strobe);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) exp_q.push_back(e);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    case (idx)
      8'h23: {m[6'h20], m[6'h21], m[6'h22]} = {3{d}};
      8'h27: {m[6'h24], m[6'h25], m[6'h26]} = {3{7'h0, d[0]}};
      8'h2b: {m[6'h28], m[6'h29], m[6'h2a]} = {3{d}};
      8'h24, 8'h25, 8'h26: m[idx[5:0]] = {7'h0, d[0]};
      8'h3f: ;
      default: m[idx[5:0]] = d;
    endcase
    bus(1'b1, idx, {24'h0, d}, 32'h0);
  endtask
  task automatic check_outs;
    repeat (2) @(posedge hclk);
    chk({7'h0, red_offset_code, green_offset_code, blue_offset_code, red_gain_code, green_gain_code,
         blue_gain_code, cell_power_disable, fast_bias_sel, gain_law_sel}, {7'h0, m[6'h20], m[6'h21], m[6'h22],
         m[6'h28], m[6'h24][0], m[6'h29], m[6'h25][0], m[6'h2a], m[6'h26][0],
         (m[6'h08][0] ? m[6'h06][3:0] : 4'h0), m[6'h07][1], m[6'h08][1]});
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) chk({31'h0, hresp, hrdata}, {32'h0, exp_q.pop_front()});
    if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    n_fail = 0;
    total_checks = 0;
    foreach (m[i]) m[i] = 8'h00;
    void'($urandom(32'h3a07));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ix[i]) bus(1'b0, ix[i], 32'h0, 32'h0);
    check_outs;
    repeat (80) begin
      k = $urandom_range(16);
      wr(ix[k], 8'($urandom) & mk[k]);
      k = $urandom_range(16);
      bus(1'b0, ix[k], 32'h0, {24'h0, m[ix[k][5:0]]});
      check_outs;
    end
    for (int d = 0; d < 32; d++) begin
      wr(8'h05, 8'(d));
      repeat (30) @(posedge hclk);
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (m[i]) m[i] = 8'h00;
    check_outs;
    end_sim();
  end
endmodule // tb
`default_nettype wire

// >>> verilog/afe_regs_consts.vh
`ifndef AFE_REGS_CONSTS_VH
`define AFE_REGS_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_STROBE_DETECT_SETUP   8'h05
`define IDX_POWER_DISABLE_MASK    8'h06
`define IDX_SPECIAL_FUNCTION      8'h07
`define IDX_ANALOG_CONTROL        8'h08
`define IDX_RED_OFFSET            8'h20
`define IDX_GREEN_OFFSET          8'h21
`define IDX_BLUE_OFFSET           8'h22
`define IDX_ALL_COLOUR_OFFSET     8'h23
`define IDX_RED_GAIN_LOW          8'h24
`define IDX_GREEN_GAIN_LOW        8'h25
`define IDX_BLUE_GAIN_LOW         8'h26
`define IDX_ALL_COLOUR_GAIN_LOW   8'h27
`define IDX_RED_GAIN_HIGH         8'h28
`define IDX_GREEN_GAIN_HIGH       8'h29
`define IDX_BLUE_GAIN_HIGH        8'h2a
`define IDX_ALL_COLOUR_GAIN_HIGH  8'h2b

// Field positions.
`define BIT_STROBE_DETECT_EN      0
`define MSB_STROBE_PULSE_DELAY    3
`define LSB_STROBE_PULSE_DELAY    1
`define BIT_STROBE_EDGE_POLARITY  4
`define MSB_CELL_DISABLE_MASK     3
`define LSB_CELL_DISABLE_MASK     0
`define BIT_FAST_BIAS_SEL         1
`define BIT_SELECTIVE_POWERDOWN   0
`define BIT_GAIN_LAW_SEL          1
`define BIT_GAIN_LOW              0

// Reset values.
`define RST_STROBE_DETECT_SETUP   8'h00
`define RST_POWER_DISABLE_MASK    4'h0
`define RST_SPECIAL_FUNCTION      8'h00
`define RST_ANALOG_CONTROL        8'h00
`define RST_OFFSET                8'h00
`define RST_GAIN_LOW              1'h0
`define RST_GAIN_HIGH             8'h00

// Bus encodings.
`define HRESP_OKAY                1'h0

`endif

// >>> verilog/afe_setup_gain_offset_regs.v
// Overview of operation
// [R1] With strobe detection off, the synchronised sampling strobe is passed straight on as the timing strobe.
// [R2] With strobe detection on, an edge of the sampling strobe produces an internal synchronisation pulse.
// [R3] That pulse follows the detected edge by as many clock periods as the 3-bit delay field, which resets to zero.
// [R4] The delay field has no effect while strobe detection is off.
// [R5] The polarity bit picks falling edges when 0 and rising edges when 1.
// [R6] The polarity bit has no effect while strobe detection is off.
// [R7] The 4-bit cell disable mask, reset to zero, acts only while selective power-down is set.
// [R8] A mask bit of 1 disables its cell; bits 0 to 2 are the red, green and blue cells and bit 3 the converter.
// [R9] The fast bias output follows bit 1 of the special function register.
// [R10] Red, green and blue each keep an 8-bit offset code that resets to zero.
// [R11] Writing the all-colour offset location loads all three offset codes.
// [R12] Each 9-bit gain code is the high register as bits 8:1 above bit 0 of the low register.
// [R13] Writing the all-colour gain low location loads all three gain low bits.
// [R14] Writing the all-colour gain high location loads all three gain high registers.
// [R15] The gain code goes to the gain stage unchanged, whatever the gain law select.
// [R16] A broadcast write updates all colours in one cycle and a single-colour write changes only that colour.
// [R17] The strobe is sampled on the clock and compared with its last value; each detected edge restarts the delay and drops any pulse still pending.
//
// Implementation choice: the AHB-Lite slave port.

`include "afe_regs_consts.vh"

`default_nettype none

module afe_setup_gain_offset_regs (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        sample_strobe_in,
  output wire        timing_strobe,
  output wire [3:0]  cell_power_disable,
  output wire        fast_bias_sel,
  output wire        gain_law_sel,
  output wire [7:0]  red_offset_code,
  output wire [7:0]  green_offset_code,
  output wire [7:0]  blue_offset_code,
  output wire [8:0]  red_gain_code,
  output wire [8:0]  green_gain_code,
  output wire [8:0]  blue_gain_code
);

  // Index of a word address when it lies in the register window, else all ones.
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      if (addr[31:10] == 22'h000000) begin
        reg_index = addr[9:2];
      end else begin
        reg_index = 8'hff;
      end
    end
  endfunction

  // True when a write index names this colour's own location or the broadcast one.
  function colour_hit;
    input [7:0]   idx;
    input [7:0]   first;
    input [7:0]   bcast;
    input integer colour;
    begin
      colour_hit = (idx == (first + colour[7:0])) || (idx == bcast);
    end
  endfunction

  // Bus side state.
  reg        hreadyout_q;
  reg        hresp_q;
  reg [31:0] hrdata_q;
  reg        wr_pend_q;
  reg [7:0]  wr_idx_q;
  reg        rd_pend_q;
  reg [7:0]  rd_idx_q;

  // Setup registers.
  reg [7:0]  strobe_setup_q;
  reg [3:0]  disable_mask_q;
  reg [7:0]  special_q;
  reg [7:0]  analog_ctrl_q;
  reg [3:0]  cell_disable_q;

  // Per-colour storage, index 0 red, 1 green, 2 blue.
  reg [7:0]  offset_q    [0:2];
  reg        gain_low_q  [0:2];
  reg [7:0]  gain_high_q [0:2];

  // Strobe path.
  reg        strobe_s1_q;
  reg        strobe_s2_q;
  reg        strobe_prev_q;
  reg [2:0]  delay_cnt_q;
  reg        delay_run_q;
  reg        timing_strobe_q;
  reg [2:0]  delay_cnt_d;
  reg        delay_run_d;
  reg        timing_strobe_d;

  wire       addr_accept;
  wire       wr_fire;
  wire       detect_en;
  wire       edge_pol;
  wire [2:0] pulse_delay;
  wire       rise_seen;
  wire       fall_seen;
  wire       edge_seen;

  reg [31:0] rd_mux;

  // A write lands at the end of its data phase, while hwdata is valid.
  assign addr_accept = hsel & htrans[1] & hready;
  assign wr_fire     = wr_pend_q;

  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;

  // Address phase capture. Reads take one wait state so that a write in the
  // preceding data phase has landed before the read value is sampled.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= `HRESP_OKAY;
      hrdata_q    <= 32'h00000000;
      wr_pend_q   <= 1'b0;
      wr_idx_q    <= 8'h00;
      rd_pend_q   <= 1'b0;
      rd_idx_q    <= 8'h00;
    end else begin
      // Every transfer, unmapped or write-only ones too, answers OKAY.
      hresp_q <= `HRESP_OKAY;
      if (rd_pend_q) begin
        hrdata_q    <= rd_mux;
        hreadyout_q <= 1'b1;
        rd_pend_q   <= 1'b0;
      end
      if (addr_accept && hwrite) begin
        wr_pend_q <= 1'b1;
        wr_idx_q  <= reg_index(haddr);
      end else if (hready) begin
        wr_pend_q <= 1'b0;
      end
      if (addr_accept && !hwrite) begin
        rd_pend_q   <= 1'b1;
        rd_idx_q    <= reg_index(haddr);
        hreadyout_q <= 1'b0;
      end
    end
  end

  // Read-back multiplexer; write-only and unmapped locations read zero.
  always @* begin
    rd_mux = 32'h00000000;
    case (rd_idx_q)
      `IDX_STROBE_DETECT_SETUP: begin
        rd_mux[7:0] = strobe_setup_q;
      end
      `IDX_POWER_DISABLE_MASK: begin
        rd_mux[3:0] = disable_mask_q;
      end
      `IDX_SPECIAL_FUNCTION: begin
        rd_mux[7:0] = special_q;
      end
      `IDX_ANALOG_CONTROL: begin
        rd_mux[7:0] = analog_ctrl_q;
      end
      `IDX_RED_OFFSET: begin
        rd_mux[7:0] = offset_q[0];
      end
      `IDX_GREEN_OFFSET: begin
        rd_mux[7:0] = offset_q[1];
      end
      `IDX_BLUE_OFFSET: begin
        rd_mux[7:0] = offset_q[2];
      end
      `IDX_RED_GAIN_LOW: begin
        rd_mux[`BIT_GAIN_LOW] = gain_low_q[0];
      end
      `IDX_GREEN_GAIN_LOW: begin
        rd_mux[`BIT_GAIN_LOW] = gain_low_q[1];
      end
      `IDX_BLUE_GAIN_LOW: begin
        rd_mux[`BIT_GAIN_LOW] = gain_low_q[2];
      end
      `IDX_RED_GAIN_HIGH: begin
        rd_mux[7:0] = gain_high_q[0];
      end
      `IDX_GREEN_GAIN_HIGH: begin
        rd_mux[7:0] = gain_high_q[1];
      end
      `IDX_BLUE_GAIN_HIGH: begin
        rd_mux[7:0] = gain_high_q[2];
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Setup register writes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_setup_q <= `RST_STROBE_DETECT_SETUP;
      disable_mask_q <= `RST_POWER_DISABLE_MASK;
      special_q      <= `RST_SPECIAL_FUNCTION;
      analog_ctrl_q  <= `RST_ANALOG_CONTROL;
    end else if (wr_fire) begin
      case (wr_idx_q)
        `IDX_STROBE_DETECT_SETUP: begin
          strobe_setup_q <= hwdata[7:0];
        end
        `IDX_POWER_DISABLE_MASK: begin
          disable_mask_q <= hwdata[`MSB_CELL_DISABLE_MASK:`LSB_CELL_DISABLE_MASK];
        end
        `IDX_SPECIAL_FUNCTION: begin
          special_q <= hwdata[7:0];
        end
        `IDX_ANALOG_CONTROL: begin
          analog_ctrl_q <= hwdata[7:0];
        end
        default: begin
          special_q <= special_q;
        end
      endcase
    end
  end

  // Cell power gating, active only under selective power-down.
  // Registered so that mask and enable changes reach the cells on one edge.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_disable_q <= `RST_POWER_DISABLE_MASK;
    end else if (analog_ctrl_q[`BIT_SELECTIVE_POWERDOWN]) begin // [R7]
      cell_disable_q <= disable_mask_q; // [R8]
    end else begin
      cell_disable_q <= 4'h0;
    end
  end

  assign cell_power_disable = cell_disable_q;
  // Bias and gain-law selects come straight from their register bits.
  assign fast_bias_sel      = special_q[`BIT_FAST_BIAS_SEL]; // [R9]
  assign gain_law_sel       = analog_ctrl_q[`BIT_GAIN_LAW_SEL];

  // Per-colour registers; each colour answers its own location and the broadcast one.
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_colour
      wire off_hit;
      wire low_hit;
      wire high_hit;

      assign off_hit  = wr_fire && colour_hit(wr_idx_q, `IDX_RED_OFFSET,
                                              `IDX_ALL_COLOUR_OFFSET, ch); // [R11] [R16]
      assign low_hit  = wr_fire && colour_hit(wr_idx_q, `IDX_RED_GAIN_LOW,
                                              `IDX_ALL_COLOUR_GAIN_LOW, ch); // [R13] [R16]
      assign high_hit = wr_fire && colour_hit(wr_idx_q, `IDX_RED_GAIN_HIGH,
                                              `IDX_ALL_COLOUR_GAIN_HIGH, ch); // [R14] [R16]

      // Offset code.
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          offset_q[ch] <= `RST_OFFSET; // [R10]
        end else if (off_hit) begin
          offset_q[ch] <= hwdata[7:0]; // [R10]
        end
      end

      // Gain low bit.
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gain_low_q[ch] <= `RST_GAIN_LOW;
        end else if (low_hit) begin
          gain_low_q[ch] <= hwdata[`BIT_GAIN_LOW];
        end
      end

      // Gain high byte.
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          gain_high_q[ch] <= `RST_GAIN_HIGH;
        end else if (high_hit) begin
          gain_high_q[ch] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // Offset codes leave the block as stored.
  assign red_offset_code   = offset_q[0];
  assign green_offset_code = offset_q[1];
  assign blue_offset_code  = offset_q[2];

  // Gain codes go out raw; the gain law is applied in the analogue stage.
  assign red_gain_code   = {gain_high_q[0], gain_low_q[0]}; // [R12] [R15]
  assign green_gain_code = {gain_high_q[1], gain_low_q[1]}; // [R12] [R15]
  assign blue_gain_code  = {gain_high_q[2], gain_low_q[2]}; // [R12] [R15]

  // Strobe synchroniser and edge detector.
  // Only the second flop feeds the edge logic; the first may go metastable.
  assign detect_en   = strobe_setup_q[`BIT_STROBE_DETECT_EN];
  assign edge_pol    = strobe_setup_q[`BIT_STROBE_EDGE_POLARITY];
  assign pulse_delay = strobe_setup_q[`MSB_STROBE_PULSE_DELAY:`LSB_STROBE_PULSE_DELAY];
  assign rise_seen   = strobe_s2_q & ~strobe_prev_q; // [R17]
  assign fall_seen   = ~strobe_s2_q & strobe_prev_q; // [R17]
  assign edge_seen   = edge_pol ? rise_seen : fall_seen; // [R5]

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_s1_q   <= 1'b0;
      strobe_s2_q   <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_s1_q   <= sample_strobe_in;
      strobe_s2_q   <= strobe_s1_q;
      strobe_prev_q <= strobe_s2_q; // [R17]
    end
  end

  // Next state of the delay counter and timing strobe. A new edge restarts the
  // delay, so a pulse still pending from an earlier edge is dropped.
  always @* begin
    delay_cnt_d     = delay_cnt_q;
    delay_run_d     = delay_run_q;
    timing_strobe_d = 1'b0; // [R17]
    if (!detect_en) begin
      // Detection off: the synchronised level passes straight through.
      delay_cnt_d     = 3'h0; // [R4] [R6]
      delay_run_d     = 1'b0;
      timing_strobe_d = strobe_s2_q; // [R1]
    end else if (edge_seen) begin // [R2]
      if (pulse_delay == 3'h0) begin
        delay_run_d     = 1'b0;
        delay_cnt_d     = 3'h0;
        timing_strobe_d = 1'b1; // [R3]
      end else begin
        delay_run_d = 1'b1;
        delay_cnt_d = pulse_delay; // [R3]
      end
    end else if (delay_run_q) begin
      // Count down; the pulse fires as the count leaves one.
      if (delay_cnt_q == 3'h1) begin
        delay_run_d     = 1'b0;
        timing_strobe_d = 1'b1; // [R3] [R17]
      end
      delay_cnt_d = delay_cnt_q - 3'h1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      delay_cnt_q     <= 3'h0;
      delay_run_q     <= 1'b0;
      timing_strobe_q <= 1'b0;
    end else begin
      delay_cnt_q     <= delay_cnt_d;
      delay_run_q     <= delay_run_d;
      timing_strobe_q <= timing_strobe_d;
    end
  end

  assign timing_strobe = timing_strobe_q;

endmodule // afe_setup_gain_offset_regs

`default_nettype wire
